//--- ftc_params.svh
// Offsets, field positions, reset values and timing counts of the tuning bank.
`ifndef FTC_PARAMS_SVH
`define FTC_PARAMS_SVH

// ==========================================================================
// Register offsets
`define FTC_OFS_READ_ADDR     5'h00
`define FTC_OFS_ENABLE        5'h01
`define FTC_OFS_SETTINGS      5'h02
`define FTC_OFS_FINE_OVR      5'h03
`define FTC_OFS_STROBE        5'h04
`define FTC_OFS_CLK_PERIOD    5'h05
`define FTC_OFS_MEAS_ADJ      5'h06
`define FTC_OFS_SPARE         5'h07
`define FTC_OFS_CAL_STATUS    5'h08
`define FTC_OFS_CAL_COUNT     5'h09
`define FTC_OFS_ST_MODE       5'h0e
`define FTC_OFS_ST_RESULT     5'h0f

// ==========================================================================
// Field positions
`define FTC_EN_CAL_BIT        1
`define FTC_EN_FORCE_BIT      4
`define FTC_STAT_BUSY_BIT     4
`define FTC_STAT_NVW_BIT      5
`define FTC_ST_BUSY_BIT       16

// ==========================================================================
// Reset values and trim limit
`define FTC_RST_AMP_BIAS      2'h1
`define FTC_RST_OUT_BIAS      2'h2
`define FTC_RST_BAND          4'h0
`define FTC_RST_PERIOD        15'h0000
`define FTC_RST_MEAS_ADJ      9'h000
`define FTC_TRIM_MAX          4'hb

// ==========================================================================
// Frame and timing
`define FTC_FRAME_BITS        6'd29
`define FTC_ADJ_STEP_PS       1024
`define FTC_CAL_CYCLES        1024
`define FTC_ST_CYCLES         262144

`endif

//--- ftc_pkg.sv
// Types shared by the filter tuning register bank.
package ftc_pkg;

   // =======================================================================
   // Analog setting group driven to the filter.
   typedef struct packed {
      logic [1:0] amp_bias;
      logic [1:0] out_bias;
      logic       gain_boost_select;
      logic       filter_skip;
      logic [3:0] coarse_band;
      logic       zin_msb;
   } ftc_settings_t;

   typedef enum logic [1:0] {
      FTC_IDLE,
      FTC_CAL,
      FTC_SELFTEST
   } ftc_state_t;

endpackage

//--- ftc_regs.sv
// Serial register bank with calibration sequencer for the tunable filter.
`timescale 1ns/10ps
`include "ftc_params.svh"

module ftc_regs #(
   parameter int CAL_CYCLES = `FTC_CAL_CYCLES,
   parameter int ST_CYCLES  = `FTC_ST_CYCLES
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  spi_sck,
   input  wire logic                  spi_sel,
   input  wire logic                  spi_sdi,
   output logic                       spi_sdo,
   input  wire logic [23:0]           cal_count,
   input  wire logic                  nonvolatile_write_active,
   output ftc_pkg::ftc_settings_t     settings,
   output logic [8:0]                 band_onehot,
   output logic [3:0]                 fine_trim,
   output logic                       cal_run,
   output logic                       rc_selftest_run
);

   // ======================================================================
   // State
   logic                   sck_q, sck_d;
   logic [5:0]             bits_q, bits_d;
   logic [28:0]            sr_q, sr_d;
   logic [23:0]            rd_q, rd_d;
   logic                   sdo_q, sdo_d;
   logic [4:0]             rd_addr_q, rd_addr_d;
   logic                   cal_en_q, cal_en_d;
   logic                   force_q, force_d;
   logic                   selftest_mode_on_q, selftest_mode_on_d;
   ftc_pkg::ftc_settings_t set_q, set_d;
   logic [3:0]             ovr_q, ovr_d;
   logic [14:0]            period_q, period_d;
   logic [8:0]             adj_q, adj_d;
   ftc_pkg::ftc_state_t    st_q, st_d;
   logic [18:0]            cnt_q, cnt_d;
   logic [3:0]             cal_trim_q, cal_trim_d;
   logic [15:0]            crc_q, crc_d;
   logic                   selftest_running_q, selftest_running_d;
   logic [8:0]             band_q, band_d;
   logic [3:0]             trim_q, trim_d;
   logic                   run_q, run_d;
   logic                   strun_q, strun_d;

   // ======================================================================
   // Helpers
   // The correction is scaled to picoseconds and added with sign.
   function automatic logic [3:0] decode_trim(input logic [23:0] raw,
                                              input logic [8:0]  adj);
      logic signed [35:0] sum;
      logic [35:0]        shifted;
      sum = $signed({12'h000, raw}) +
            $signed({{27{adj[8]}}, adj}) * 36'(`FTC_ADJ_STEP_PS);
      // A negative sum clamps to the lowest trim instead of wrapping.
      shifted = 36'(sum) >> 12;
      if (sum < 0) begin
         decode_trim = 4'h0;
      end else if (shifted > 36'(`FTC_TRIM_MAX)) begin
         decode_trim = `FTC_TRIM_MAX;
      end else begin
         decode_trim = shifted[3:0];
      end
   endfunction

   function automatic logic [23:0] read_reg(input logic [4:0] a);
      read_reg = 24'h000000;
      case (a)
         `FTC_OFS_ENABLE: begin
            read_reg[`FTC_EN_CAL_BIT]   = cal_en_q;
            read_reg[`FTC_EN_FORCE_BIT] = force_q;
         end
         `FTC_OFS_SETTINGS: begin
            read_reg[1:0] = set_q.amp_bias;
            read_reg[3:2] = set_q.out_bias;
            read_reg[4]   = set_q.gain_boost_select;
            read_reg[5]   = set_q.filter_skip;
            read_reg[9:6] = set_q.coarse_band;
            read_reg[10]  = set_q.zin_msb;
         end
         `FTC_OFS_FINE_OVR:   read_reg[3:0]  = ovr_q;
         `FTC_OFS_CLK_PERIOD: read_reg[14:0] = period_q;
         `FTC_OFS_MEAS_ADJ:   read_reg[8:0]  = adj_q;
         `FTC_OFS_CAL_STATUS: begin
            read_reg[3:0] = cal_trim_q;
            read_reg[`FTC_STAT_BUSY_BIT] = (st_q == ftc_pkg::FTC_CAL);
            read_reg[`FTC_STAT_NVW_BIT]  = nonvolatile_write_active;
         end
         `FTC_OFS_CAL_COUNT:  read_reg = cal_count;
         `FTC_OFS_ST_MODE:    read_reg[0] = selftest_mode_on_q;
         `FTC_OFS_ST_RESULT: begin
            read_reg[15:0] = crc_q;
            read_reg[`FTC_ST_BUSY_BIT] = selftest_running_q;
         end
         default:             read_reg = 24'h000000;
      endcase
   endfunction

   // ======================================================================
   // Next state
   always_comb begin
      logic        rise;
      logic        fall;
      logic        wr;
      logic [4:0]  wa;
      logic [23:0] wd;
      rise = 1'b0;
      fall = 1'b0;
      wr   = 1'b0;
      wa   = sr_q[4:0];
      wd   = sr_q[28:5];
      sck_d = spi_sck;
      bits_d = bits_q;
      sr_d = sr_q;
      rd_d = rd_q;
      sdo_d = sdo_q;
      rd_addr_d = rd_addr_q;
      cal_en_d = cal_en_q;
      force_d = force_q;
      selftest_mode_on_d = selftest_mode_on_q;
      set_d = set_q;
      ovr_d = ovr_q;
      period_d = period_q;
      adj_d = adj_q;
      st_d = st_q;
      cnt_d = cnt_q;
      cal_trim_d = cal_trim_q;
      crc_d = crc_q;
      selftest_running_d = selftest_running_q;
      rise = spi_sel && spi_sck && !sck_q;
      fall = spi_sel && !spi_sck && sck_q;
      if (!spi_sel) begin
         // A frame that is cut short is dropped without a write.
         wr = (bits_q == `FTC_FRAME_BITS);
         bits_d = 6'd0;
         rd_d = read_reg(rd_addr_q);
         sdo_d = 1'b0;
      end else begin
         if (rise && bits_q != `FTC_FRAME_BITS) begin
            sr_d = {sr_q[27:0], spi_sdi};
            bits_d = bits_q + 6'd1;
         end
         if (fall) begin
            sdo_d = rd_q[23];
            rd_d = {rd_q[22:0], 1'b0};
         end
      end
      if (wr) begin
         case (wa)
            `FTC_OFS_READ_ADDR: rd_addr_d = wd[4:0];
            `FTC_OFS_ENABLE: begin
               cal_en_d = wd[`FTC_EN_CAL_BIT];
               force_d  = wd[`FTC_EN_FORCE_BIT];
            end
            `FTC_OFS_SETTINGS: begin
               // The carrier lists its fields in the reverse of the register
               // bit order, so each field is placed by hand.
               set_d.amp_bias          = wd[1:0];
               set_d.out_bias          = wd[3:2];
               set_d.gain_boost_select = wd[4];
               set_d.filter_skip       = wd[5];
               set_d.coarse_band       = wd[9:6];
               set_d.zin_msb           = wd[10];
            end
            `FTC_OFS_FINE_OVR:   ovr_d = wd[3:0];
            `FTC_OFS_CLK_PERIOD: period_d = wd[14:0];
            `FTC_OFS_MEAS_ADJ:   adj_d = wd[8:0];
            `FTC_OFS_ST_MODE:    selftest_mode_on_d = wd[0];
            default: ;
         endcase
      end
      case (st_q)
         ftc_pkg::FTC_IDLE: begin
            // Data of the strobe write is never looked at.
            if (wr && wa == `FTC_OFS_STROBE) begin
               cnt_d = 19'd0;
               if (selftest_mode_on_q) begin
                  st_d = ftc_pkg::FTC_SELFTEST;
                  selftest_running_d = 1'b1;
                  crc_d = 16'hffff;
               end else begin
                  st_d = ftc_pkg::FTC_CAL;
               end
            end
         end
         ftc_pkg::FTC_CAL: begin
            // The sequence waits while the circuit is disabled.
            if (cal_en_q) begin
               cnt_d = cnt_q + 19'd1;
               if (cnt_q == 19'(CAL_CYCLES - 1)) begin
                  cal_trim_d = decode_trim(cal_count, adj_q);
                  st_d = ftc_pkg::FTC_IDLE;
               end
            end
         end
         ftc_pkg::FTC_SELFTEST: begin
            cnt_d = cnt_q + 19'd1;
            crc_d = {crc_q[14:0], 1'b0} ^
                    ((crc_q[15] ^ cal_count[0] ^ period_q[0] ^ adj_q[0])
                     ? 16'h1021 : 16'h0000);
            if (cnt_q == 19'(ST_CYCLES - 1)) begin
               selftest_running_d = 1'b0;
               st_d = ftc_pkg::FTC_IDLE;
            end
         end
         default: st_d = ftc_pkg::FTC_IDLE;
      endcase
      band_d = (set_q.coarse_band <= 4'h8)
             ? 9'(9'h001 << set_q.coarse_band) : 9'h000;
      trim_d = force_q ? ovr_q : cal_trim_q;
      run_d = cal_en_q && (st_q == ftc_pkg::FTC_CAL);
      strun_d = (st_q == ftc_pkg::FTC_SELFTEST);
   end

   // ======================================================================
   // Registers
   always_ff @(posedge clk) begin
      if (rst) begin
         sck_q <= 1'b0;
         bits_q <= 6'd0;
         sr_q <= 29'h0;
         rd_q <= 24'h0;
         sdo_q <= 1'b0;
         rd_addr_q <= 5'h00;
         cal_en_q <= 1'b0;
         force_q <= 1'b0;
         selftest_mode_on_q <= 1'b0;
         set_q <= '{amp_bias: `FTC_RST_AMP_BIAS,
                    out_bias: `FTC_RST_OUT_BIAS,
                    gain_boost_select: 1'b0,
                    filter_skip: 1'b0,
                    coarse_band: `FTC_RST_BAND,
                    zin_msb: 1'b0};
         ovr_q <= 4'h0;
         period_q <= `FTC_RST_PERIOD;
         adj_q <= `FTC_RST_MEAS_ADJ;
         st_q <= ftc_pkg::FTC_IDLE;
         cnt_q <= 19'd0;
         cal_trim_q <= 4'h0;
         crc_q <= 16'h0000;
         selftest_running_q <= 1'b0;
         band_q <= 9'h000;
         trim_q <= 4'h0;
         run_q <= 1'b0;
         strun_q <= 1'b0;
      end else begin
         sck_q <= sck_d;
         bits_q <= bits_d;
         sr_q <= sr_d;
         rd_q <= rd_d;
         sdo_q <= sdo_d;
         rd_addr_q <= rd_addr_d;
         cal_en_q <= cal_en_d;
         force_q <= force_d;
         selftest_mode_on_q <= selftest_mode_on_d;
         set_q <= set_d;
         ovr_q <= ovr_d;
         period_q <= period_d;
         adj_q <= adj_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         cal_trim_q <= cal_trim_d;
         crc_q <= crc_d;
         selftest_running_q <= selftest_running_d;
         band_q <= band_d;
         trim_q <= trim_d;
         run_q <= run_d;
         strun_q <= strun_d;
      end
   end

   assign spi_sdo         = sdo_q;
   assign settings        = set_q;
   assign band_onehot     = band_q;
   assign fine_trim       = trim_q;
   assign cal_run         = run_q;
   assign rc_selftest_run = strun_q;

endmodule // ftc_regs

//--- ftc_regs_props.sv
// Concurrent checks on the ports of the filter tuning register bank.
`timescale 1ns/10ps
// ==========================================================================
// Checker
module ftc_regs_props #(
   parameter int CAL_CYCLES = 1024,
   parameter int ST_CYCLES  = 262144
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              spi_sck,
   input wire logic              spi_sel,
   input wire logic              spi_sdi,
   input wire logic              spi_sdo,
   input wire logic [23:0]       cal_count,
   input wire logic              nonvolatile_write_active,
   input ftc_pkg::ftc_settings_t settings,
   input wire logic [8:0]        band_onehot,
   input wire logic [3:0]        fine_trim,
   input wire logic              cal_run,
   input wire logic              rc_selftest_run
);
   logic [19:0] cal_len_q, cal_len_d, st_len_q, st_len_d;

   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);

   // Run lengths are counted here because the counts exceed a repetition.
   always_comb begin
      cal_len_d = (rst || !cal_run) ? 20'h00000 : cal_len_q + 20'h00001;
      st_len_d  = (rst || !rc_selftest_run) ? 20'h00000
                                            : st_len_q + 20'h00001;
   end
   always_ff @(posedge clk) begin
      cal_len_q <= cal_len_d;
      st_len_q  <= st_len_d;
   end

   property p_reset_vals;
      $fell(rst) |-> settings.amp_bias == 2'h1 && settings.out_bias == 2'h2
         && !settings.gain_boost_select && !settings.filter_skip
         && settings.coarse_band == 4'h0 && !cal_run && !rc_selftest_run;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("reset value");
   property p_band;
      settings.coarse_band <= 4'h8
         |=> band_onehot == 9'h001 << $past(settings.coarse_band);
   endproperty
   a_band: assert property (p_band)
      else $error("band decode wrong");
   property p_band_none;
      settings.coarse_band > 4'h8 |=> band_onehot == 9'h000;
   endproperty
   a_band_none: assert property (p_band_none)
      else $error("bad band on");
   property p_trim_range;
      fine_trim <= 4'hb;
   endproperty
   a_trim_range: assert property (p_trim_range)
      else $error("trim range");
   property p_excl;
      !(cal_run && rc_selftest_run);
   endproperty
   a_excl: assert property (p_excl)
      else $error("both engines run");
   property p_set_frame;
      $changed(settings) |-> !$past(spi_sel) || !$past(spi_sel, 3);
   endproperty
   a_set_frame: assert property (p_set_frame)
      else $error("stray update");
   property p_sdo;
      spi_sel && spi_sck |-> $stable(spi_sdo);
   endproperty
   a_sdo: assert property (p_sdo)
      else $error("read bit moved early");
   property p_cal_len;
      $fell(cal_run) |-> cal_len_q >= CAL_CYCLES - 1
         && cal_len_q <= CAL_CYCLES + 1;
   endproperty
   a_cal_len: assert property (p_cal_len)
      else $error("cal length");
   property p_st_len;
      $fell(rc_selftest_run) |-> st_len_q >= ST_CYCLES - 1
         && st_len_q <= ST_CYCLES + 1;
   endproperty
   a_st_len: assert property (p_st_len)
      else $error("self test length");

   c_cal: cover property ($fell(cal_run));
   c_st: cover property ($fell(rc_selftest_run));
   c_band8: cover property (band_onehot == 9'h100);
endmodule // ftc_regs_props

bind ftc_regs ftc_regs_props #(.CAL_CYCLES(CAL_CYCLES), .ST_CYCLES(ST_CYCLES))
   u_props (.clk(clk), .rst(rst), .spi_sck(spi_sck), .spi_sel(spi_sel),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .cal_count(cal_count),
      .nonvolatile_write_active(nonvolatile_write_active),
      .settings(settings), .band_onehot(band_onehot), .fine_trim(fine_trim),
      .cal_run(cal_run), .rc_selftest_run(rc_selftest_run));

//--- ftc_host_model.sv
// Host controller model that drives serial frames into the tuning bank.
`timescale 1ns/10ps
// ==========================================================================
// Serial host
module ftc_host_model (
   input  wire logic clk,
   output logic      spi_sck,
   output logic      spi_sel,
   output logic      spi_sdi,
   input  wire logic spi_sdo
);
   initial begin
      spi_sck = 1'b0;
      spi_sel = 1'b0;
      spi_sdi = 1'b0;
   end

   // Each serial phase spans several clocks since the bank oversamples it.
   task automatic xfer(input logic [4:0] a, input logic [23:0] d,
                       output logic [23:0] q);
      logic [28:0] f;
      f = {d, a};
      q = 24'h000000;
      @(posedge clk);
      spi_sel <= 1'b1;
      for (int i = 28; i >= 0; i--) begin
         @(posedge clk);
         spi_sdi <= f[i];
         @(posedge clk);
         spi_sck <= 1'b1;
         repeat (2) @(posedge clk);
         spi_sck <= 1'b0;
         repeat (3) @(posedge clk);
         if (i > 4) q[i-5] = spi_sdo;
      end
      spi_sel <= 1'b0;
      // Data line is left moving so a stale bit cannot pass as a real one.
      spi_sdi <= ~f[0];
      @(posedge clk);
   endtask
endmodule // ftc_host_model

//--- ftc_regs_tb.sv
// Self-checking bench for the filter tuning register bank.
`timescale 1ns/10ps
// ==========================================================================
// Bench top
module ftc_regs_tb;
   logic                   clk, rst, spi_sck, spi_sel, spi_sdi, spi_sdo;
   logic                   nonvolatile_write_active;
   logic [23:0]            cal_count, q;
   ftc_pkg::ftc_settings_t settings;
   logic [8:0]             band_onehot;
   logic [3:0]             fine_trim;
   logic                   cal_run, rc_selftest_run;
   int                     fail_count, check_count;

   ftc_regs #(.CAL_CYCLES(300), .ST_CYCLES(300)) dut (.clk(clk), .rst(rst),
      .spi_sck(spi_sck), .spi_sel(spi_sel), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .cal_count(cal_count),
      .nonvolatile_write_active(nonvolatile_write_active),
      .settings(settings), .band_onehot(band_onehot), .fine_trim(fine_trim),
      .cal_run(cal_run), .rc_selftest_run(rc_selftest_run));
   ftc_host_model host (.clk(clk), .spi_sck(spi_sck), .spi_sel(spi_sel),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      logic [23:0] dummy;
      host.xfer(a, d, dummy);
   endtask
   task automatic rd(input logic [4:0] a, output logic [23:0] d);
      logic [23:0] dummy;
      host.xfer(5'h00, {19'h00000, a}, dummy);
      host.xfer(5'h00, {19'h00000, a}, d);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_idle();
      int n;
      for (n = 0; n < 2000 && (cal_run !== 1'b0 || rc_selftest_run !== 1'b0);
           n++) @(posedge clk);
      if (n == 2000) begin
         fail_count++;
         finish_test();
      end
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      logic [4:0]  adr [5] = '{5'h02, 5'h03, 5'h05, 5'h06, 5'h08};
      logic [23:0] exp [5] = '{24'h000009, 24'h0, 24'h0, 24'h0, 24'h0};
      check({13'h0000, settings}, 24'h000300);
      check({15'h0000, band_onehot}, 24'h000001);
      for (int i = 0; i < 5; i++) begin
         rd(adr[i], q);
         check(q, exp[i]);
      end
      $display("t_reset done");
   endtask
   task automatic t_settings();
      logic [23:0] d;
      wr(5'h02, 24'hffffff);
      rd(5'h02, q);
      check(q, 24'h0007ff);
      check({15'h0000, band_onehot}, 24'h000000);
      for (int c = 0; c < 9; c++) begin
         d = (24'(c) << 6) | (c[0] ? 24'h00003a : 24'h000005);
         wr(5'h02, d);
         repeat (3) @(posedge clk);
         check({13'h0000, settings}, {13'h0000, d[1:0], d[3:2], d[4], d[5],
            d[9:6], d[10]});
         check({15'h0000, band_onehot}, 24'h000001 << c);
      end
      wr(5'h07, 24'hffffff);
      rd(5'h07, q);
      check(q, 24'h000000);
      $display("t_settings done");
   endtask
   task automatic t_cal();
      cal_count <= 24'd20000;
      nonvolatile_write_active <= 1'b1;
      wr(5'h05, 24'h0061a8); // Period goes in before any strobe.
      wr(5'h06, 24'h0001ff);
      wr(5'h00, 24'h000008);
      wr(5'h04, 24'h5a5a5a);
      repeat (20) @(posedge clk);
      check({23'h000000, cal_run}, 24'h000000);
      wr(5'h01, 24'h000002);
      host.xfer(5'h00, 24'h000008, q);
      check({23'h000000, cal_run}, 24'h000001);
      host.xfer(5'h00, 24'h000008, q);
      check({22'h000000, q[5:4]}, 24'h000003);
      wait_idle();
      rd(5'h08, q);
      check(q, 24'h000024);
      check({20'h00000, fine_trim}, 24'h000004);
      nonvolatile_write_active <= 1'b0;
      wr(5'h03, 24'h000009); // Host keeps trim within range.
      wr(5'h01, 24'h000012);
      repeat (3) @(posedge clk);
      check({20'h00000, fine_trim}, 24'h000009);
      rd(5'h01, q);
      check(q, 24'h000012);
      wr(5'h01, 24'h000002);
      repeat (3) @(posedge clk);
      check({20'h00000, fine_trim}, 24'h000004);
      $display("t_cal done");
   endtask
   task automatic t_selftest();
      wr(5'h0e, 24'h000001);
      wr(5'h00, 24'h00000f);
      wr(5'h04, 24'h000000);
      repeat (3) @(posedge clk);
      check({22'h0, cal_run, rc_selftest_run}, 24'h000001);
      host.xfer(5'h00, 24'h00000f, q);
      host.xfer(5'h00, 24'h00000f, q);
      check({23'h000000, q[16]}, 24'h000001);
      wait_idle();
      rd(5'h0f, q);
      check({23'h000000, q[16]}, 24'h000000);
      $display("t_selftest done");
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      cal_count = 24'h000000;
      nonvolatile_write_active = 1'b0;
      fail_count = 0;
      check_count = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_settings();
      t_cal();
      t_selftest();
      finish_test();
   end
endmodule // ftc_regs_tb
